// >>> logic/touch_defines.svh
// Register offsets, field positions and reset values of the touch key tracker
`ifndef TOUCH_DEFINES_SVH
`define TOUCH_DEFINES_SVH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define A_CMD 8'h00
`define A_COEF1 8'h04
`define A_COEF2 8'h08
`define A_GUARD 8'h0c
`define A_KEYSEL 8'h10
`define A_SETUP_THR 8'h14
`define A_SETUP_TIME 8'h18
`define A_HYST 8'h1c
`define A_DET_LO 8'h20
`define A_DET_HI 8'h24
`define A_ERR_LO 8'h28
`define A_ERR_HI 8'h2c
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CMD_RECAL_ONE 0
`define CMD_RECAL_ALL 1
`define CMD_LOCK 2
`define CMD_KEY_LSB 8
`define GUARD_POS_LSB 8
// -----------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------
`define RST_COEF1 16'h05e9
`define RST_COEF2 8'h08
`define REF_HIGH_LIMIT 8'hbf
`define REF_LOW_LIMIT 8'h40
`define NEG_PCT_MAX 8'h63
`define POS_STEP_MAX 8'h64
`define PCT_FULL 32'h0000_0064
`define POS_STEP_PCT 32'h0000_000a
`endif

// >>> logic/touch_pkg.sv
// Types shared by the touch key tracker and its helpers
`default_nettype none
package touch_pkg;
    typedef struct packed {
        logic [3:0] di_limit;
        logic [7:0] pos_thr;
        logic [7:0] neg_thr;
    } setup_thr_t;
    typedef struct packed {
        logic [7:0] pos_delay;
        logic [7:0] neg_delay;
        logic [7:0] drift_down;
        logic [7:0] drift_up;
    } setup_time_t;
    typedef struct packed {
        logic [17:0] locked_abs;
        logic [7:0] pos_tmr;
        logic [7:0] neg_tmr;
        logic [7:0] drift_cnt;
        logic [3:0] detection_integrator;
        logic [7:0] ref_lvl;
    } key_state_t;
    typedef struct packed {
        logic [5:0] key;
        logic [7:0] signal;
        logic [1:0] coarse_offset_capacitor;
        logic [7:0] ladder_offset;
    } sample_t;
    typedef enum logic [1:0] {HYST_12P5, HYST_25, HYST_50} hyst_t;
endpackage : touch_pkg
`default_nettype wire

// >>> logic/key_ram.sv
// Small per-key memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module key_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (WIDTH < 1 || DEPTH < 2) begin : g_chk
        $error("key_ram needs WIDTH >= 1 and DEPTH >= 2");
    end

    // Read returns old data on a same-address write
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule : key_ram
`default_nettype wire

// >>> logic/guard_band.sv
// Absolute key reference and guardband comparison
`timescale 1ns/10ps
`default_nettype none
`include "touch_defines.svh"
module guard_band (
    input wire logic [15:0] coef1,
    input wire logic [7:0] coef2,
    input wire logic [1:0] ncz,
    input wire logic [7:0] offset,
    input wire logic [7:0] ref_lvl,
    input wire logic [17:0] locked_abs,
    input wire logic [7:0] neg_pct,
    input wire logic [7:0] pos_step,
    output logic [17:0] abs_ref,
    output logic too_low,
    output logic too_high
);
    logic [17:0] part_cz;
    logic [17:0] part_ofs;
    logic [31:0] cur_x100;
    logic [31:0] low_bound;
    logic [31:0] high_bound;

    // Weighted coarse and fine offsets plus window reference
    assign part_cz = 18'(coef1) * 18'(ncz);
    assign part_ofs = 18'(coef2) * 18'(offset);
    assign abs_ref = part_cz + part_ofs + 18'(ref_lvl);

    // Compare in percent units to avoid a divider
    assign cur_x100 = 32'(abs_ref) * `PCT_FULL;
    assign low_bound = 32'(locked_abs) * (`PCT_FULL - 32'(neg_pct));
    assign high_bound = 32'(locked_abs) * (`PCT_FULL + 32'(pos_step) * `POS_STEP_PCT);
    assign too_low = (neg_pct != 8'h00) && (cur_x100 < low_bound);
    assign too_high = (pos_step != 8'h00) && (cur_x100 > high_bound);
endmodule : guard_band
`default_nettype wire

// >>> logic/touch_key_tracker.sv
// Per-key reference tracking, detection integrator and error flags
`timescale 1ns/10ps
`default_nettype none
`include "touch_defines.svh"
// -----------------------------------------------------------------
// Function
// - Idle keys drift reference slowly toward signal
// - Threshold and hysteresis follow the reference
// - Drift stops once negative threshold crossed
// - Separate upward and downward drift rates
// - Per-key drift rate, zero disables drift
// - Drift saturates at window ends, flags error
// - Long detection fast-recalibrates reference to signal
// - Key works normally after fast recalibration
// - Per-key negative delay, zero disables
// - Integrator counts up below threshold, confirms
// - Between hysteresis and threshold, count down
// - Above hysteresis, undetected key's integrator clears at once
// - Released key stays detected until zero
// - Zero integrator limit disables detection
// - Integrator limit is four-bit per key
// - Long positive excursion fast-recalibrates key
// - Per-key positive interval, zero disables
// - Only reset or command does full recalibration
// - Lock stores reference, deviations become errors
// - Guardbands active only after post-lock recalibration
// - Guardband percent limits, zero disables direction
// - Absolute reference from coefficients and offsets
// - Guardband faults set error bits, summary
// - Reference above 191 or below 64 flags
// -----------------------------------------------------------------
module touch_key_tracker #(
    parameter int NKEYS = 64
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic sample_valid,
    input wire touch_pkg::sample_t sample,
    output logic [NKEYS-1:0] key_detect,
    output logic [NKEYS-1:0] full_recal_req
);
    localparam logic [63:0] KEY_MASK = {64{1'b1}} >> (64 - NKEYS);

    if (NKEYS < 1 || NKEYS > 64) begin : g_chk
        $error("NKEYS must lie between 1 and 64");
    end

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] add_sat(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        add_sat = s[8] ? 8'hff : s[7:0];
    endfunction : add_sat

    function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
        sub_sat = (a > b) ? a - b : 8'h00;
    endfunction : sub_sat

    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] top);
        clamp = (v > top) ? top : v;
    endfunction : clamp

    // -------------------------------------------------------------
    // Register port
    // -------------------------------------------------------------
    logic [15:0] coef1_q;
    logic [7:0] coef2_q;
    logic [7:0] neg_pct_q;
    logic [7:0] pos_step_q;
    logic [5:0] keysel_q;
    touch_pkg::hyst_t hyst_q;
    logic [31:0] rdata_q;
    logic [31:0] rmux;
    logic wr_cmd, wr_coef1, wr_coef2, wr_guard, wr_keysel, wr_thr, wr_time, wr_hyst;

    // Write decode
    assign wr_cmd = reg_wr && (reg_addr == `A_CMD);
    assign wr_coef1 = reg_wr && (reg_addr == `A_COEF1);
    assign wr_coef2 = reg_wr && (reg_addr == `A_COEF2);
    assign wr_guard = reg_wr && (reg_addr == `A_GUARD);
    assign wr_keysel = reg_wr && (reg_addr == `A_KEYSEL);
    assign wr_thr = reg_wr && (reg_addr == `A_SETUP_THR);
    assign wr_time = reg_wr && (reg_addr == `A_SETUP_TIME);
    assign wr_hyst = reg_wr && (reg_addr == `A_HYST);

    // Global setup registers; out-of-range percents clamp
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coef1_q <= `RST_COEF1;
            coef2_q <= `RST_COEF2;
            neg_pct_q <= 8'h00;
            pos_step_q <= 8'h00;
            keysel_q <= 6'h00;
            hyst_q <= touch_pkg::HYST_25;
        end else begin
            if (wr_coef1) coef1_q <= reg_wdata[15:0];
            if (wr_coef2) coef2_q <= reg_wdata[7:0];
            if (wr_guard) begin
                neg_pct_q <= clamp(reg_wdata[7:0], `NEG_PCT_MAX);
                pos_step_q <= clamp(reg_wdata[`GUARD_POS_LSB +: 8], `POS_STEP_MAX);
            end
            if (wr_keysel) keysel_q <= reg_wdata[5:0];
            if (wr_hyst) hyst_q <= touch_pkg::hyst_t'(reg_wdata[1:0]);
        end
    end

    // -------------------------------------------------------------
    // Per-key setups and state
    // -------------------------------------------------------------
    logic s1_v_q;
    touch_pkg::sample_t smp_q;
    logic [5:0] kq;
    touch_pkg::setup_thr_t su0;
    touch_pkg::setup_time_t su1;
    touch_pkg::key_state_t st;
    touch_pkg::key_state_t nx;
    touch_pkg::key_state_t st_wd;
    logic take;

    // Samples of keys beyond NKEYS are dropped
    assign take = sample_valid && (64'(sample.key) < 64'(NKEYS));
    assign kq = smp_q.key;

    key_ram #(.WIDTH($bits(touch_pkg::setup_thr_t)), .DEPTH(64)) u_thr (
        .clk(clk),
        .wr_en(wr_thr),
        .wr_addr(keysel_q),
        .wr_data(reg_wdata[$bits(touch_pkg::setup_thr_t)-1:0]),
        .rd_addr(sample.key),
        .rd_data_q(su0)
    );

    key_ram #(.WIDTH($bits(touch_pkg::setup_time_t)), .DEPTH(64)) u_time (
        .clk(clk),
        .wr_en(wr_time),
        .wr_addr(keysel_q),
        .wr_data(reg_wdata),
        .rd_addr(sample.key),
        .rd_data_q(su1)
    );

    key_ram #(.WIDTH($bits(touch_pkg::key_state_t)), .DEPTH(64)) u_state (
        .clk(clk),
        .wr_en(s1_v_q),
        .wr_addr(kq),
        .wr_data(st_wd),
        .rd_addr(sample.key),
        .rd_data_q(st)
    );

    // Stage register lines up with the memory read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_v_q <= 1'b0;
            smp_q <= '0;
        end else begin
            s1_v_q <= take;
            if (take) smp_q <= sample;
        end
    end

    // -------------------------------------------------------------
    // Levels derived from the stored reference
    // -------------------------------------------------------------
    logic [63:0] cal_q, lockp_q, locked_q, gbon_q, det_q, eh_q, el_q;
    logic cal, det_old, below, above_hys, above_pos;
    logic [7:0] sig, thr_lvl, hys_lvl, pos_lvl, hys_part, drift_rate;
    logic [3:0] di_inc, di_dec;

    assign sig = smp_q.signal;
    assign cal = cal_q[kq];
    assign det_old = det_q[kq];
    assign hys_part = (hyst_q == touch_pkg::HYST_50) ? su0.neg_thr >> 1 :
                      (hyst_q == touch_pkg::HYST_25) ? su0.neg_thr >> 2 : su0.neg_thr >> 3;
    assign thr_lvl = sub_sat(st.ref_lvl, su0.neg_thr);
    assign hys_lvl = add_sat(thr_lvl, hys_part);
    assign pos_lvl = add_sat(st.ref_lvl, su0.pos_thr);
    assign below = sig < thr_lvl;
    assign above_hys = sig > hys_lvl;
    assign above_pos = sig > pos_lvl;
    assign di_inc = 4'(st.detection_integrator + 4'h1);
    assign di_dec = (st.detection_integrator == 4'h0) ? 4'h0 : 4'(st.detection_integrator - 4'h1);
    assign drift_rate = (sig > st.ref_lvl) ? su1.drift_up : su1.drift_down;

    // -------------------------------------------------------------
    // Next key state, evaluated once per sample
    // -------------------------------------------------------------
    logic nx_det, neg_fire, pos_fire;

    always_comb begin
        nx = st;
        nx_det = det_old;
        neg_fire = 1'b0;
        pos_fire = 1'b0;
        if (cal) begin
            // Full recal result arrives with this sample
            nx.ref_lvl = sig;
            nx.detection_integrator = 4'h0;
            nx.drift_cnt = 8'h00;
            nx.neg_tmr = 8'h00;
            nx.pos_tmr = 8'h00;
            nx_det = 1'b0;
        end else begin
            if (su0.di_limit == 4'h0) begin
                nx.detection_integrator = 4'h0;
                nx_det = 1'b0;
            end else if (!det_old) begin
                if (below) begin
                    nx.detection_integrator = di_inc;
                    nx_det = (di_inc >= su0.di_limit);
                end else if (!above_hys) begin
                    nx.detection_integrator = di_dec;
                end else begin
                    nx.detection_integrator = 4'h0;
                end
            end else if (below) begin
                nx.detection_integrator = su0.di_limit;
            end else begin
                nx.detection_integrator = di_dec;
                nx_det = (di_dec != 4'h0);
            end
            // Detection duration timer
            if (nx_det) begin
                nx.neg_tmr = add_sat(st.neg_tmr, 8'h01);
                neg_fire = (su1.neg_delay != 8'h00) && (nx.neg_tmr >= su1.neg_delay);
            end else begin
                nx.neg_tmr = 8'h00;
            end
            // Positive excursion timer
            if (above_pos) begin
                nx.pos_tmr = add_sat(st.pos_tmr, 8'h01);
                pos_fire = (su1.pos_delay != 8'h00) && (nx.pos_tmr >= su1.pos_delay);
            end else begin
                nx.pos_tmr = 8'h00;
            end
            if (neg_fire || pos_fire) begin
                // Fast recal keeps offset and capacitor state
                nx.ref_lvl = sig;
                nx.detection_integrator = 4'h0;
                nx_det = 1'b0;
                nx.neg_tmr = 8'h00;
                nx.pos_tmr = 8'h00;
                nx.drift_cnt = 8'h00;
            end else if (det_old || nx_det || below || sig == st.ref_lvl) begin
                nx.drift_cnt = 8'h00;
            end else if (drift_rate == 8'h00) begin
                nx.drift_cnt = 8'h00;
            end else if (add_sat(st.drift_cnt, 8'h01) >= drift_rate) begin
                // One count per rate period; add_sat and sub_sat peg at 8'hff and 8'h00
                nx.drift_cnt = 8'h00;
                nx.ref_lvl = (sig > st.ref_lvl) ? add_sat(st.ref_lvl, 8'h01) :
                             sub_sat(st.ref_lvl, 8'h01);
            end else begin
                nx.drift_cnt = add_sat(st.drift_cnt, 8'h01);
            end
        end
    end

    // -------------------------------------------------------------
    // Lock and guardband
    // -------------------------------------------------------------
    logic [17:0] abs_ref;
    logic gb_low, gb_high, lock_now, hi_err, lo_err;

    guard_band u_guard (
        .coef1(coef1_q),
        .coef2(coef2_q),
        .ncz(smp_q.coarse_offset_capacitor),
        .offset(smp_q.ladder_offset),
        .ref_lvl(nx.ref_lvl),
        .locked_abs(st.locked_abs),
        .neg_pct(neg_pct_q),
        .pos_step(pos_step_q),
        .abs_ref(abs_ref),
        .too_low(gb_low),
        .too_high(gb_high)
    );

    assign lock_now = lockp_q[kq];
    assign st_wd = {lock_now ? abs_ref : st.locked_abs, nx[35:0]};
    // Guard limits only apply once armed by a post-lock recal
    assign hi_err = (nx.ref_lvl > `REF_HIGH_LIMIT) || (gbon_q[kq] && gb_high);
    assign lo_err = (nx.ref_lvl < `REF_LOW_LIMIT) || (gbon_q[kq] && gb_low);

    // -------------------------------------------------------------
    // Per-key flag vectors; a set beats a same-cycle clear
    // -------------------------------------------------------------
    logic [63:0] k1hot, k_cal, k_done, cal_set, lock_set;
    logic [63:0] cal_d, lockp_d, locked_d, gbon_d, det_d, eh_d, el_d;

    assign k1hot = 64'h1 << kq;
    assign k_done = s1_v_q ? k1hot : 64'h0;
    assign k_cal = (s1_v_q && cal) ? k1hot : 64'h0;
    assign cal_set = !wr_cmd ? 64'h0 :
                     reg_wdata[`CMD_RECAL_ALL] ? KEY_MASK :
                     reg_wdata[`CMD_RECAL_ONE] ? (64'h1 << reg_wdata[`CMD_KEY_LSB +: 6]) & KEY_MASK : 64'h0;
    assign lock_set = (wr_cmd && reg_wdata[`CMD_LOCK]) ? KEY_MASK : 64'h0;
    assign cal_d = (cal_q & ~k_cal) | cal_set;
    assign lockp_d = (lockp_q & ~(lock_now ? k_done : 64'h0)) | lock_set;
    assign locked_d = locked_q | (lock_now ? k_done : 64'h0);
    assign gbon_d = gbon_q | (locked_q[kq] ? k_cal : 64'h0);
    assign det_d = nx_det ? det_q | k_done : det_q & ~k_done;
    // Errors drop only at a full recal, never by themselves
    assign eh_d = (eh_q & ~k_cal) | (hi_err ? k_done : 64'h0);
    assign el_d = (el_q & ~k_cal) | (lo_err ? k_done : 64'h0);

    // Reset requests a full recal of every key
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_q <= KEY_MASK;
            lockp_q <= 64'h0;
            locked_q <= 64'h0;
            gbon_q <= 64'h0;
            det_q <= 64'h0;
            eh_q <= 64'h0;
            el_q <= 64'h0;
        end else begin
            cal_q <= cal_d;
            lockp_q <= lockp_d;
            locked_q <= locked_d;
            gbon_q <= gbon_d;
            det_q <= det_d;
            eh_q <= eh_d;
            el_q <= el_d;
        end
    end

    assign key_detect = det_q[NKEYS-1:0];
    assign full_recal_req = cal_q[NKEYS-1:0];

    // -------------------------------------------------------------
    // Read mux; data stand only in the cycle after the strobe
    // -------------------------------------------------------------
    logic [63:0] err_all;

    assign err_all = eh_q | el_q;

    always_comb begin
        if (reg_addr == `A_COEF1) rmux = {16'h0, coef1_q};
        else if (reg_addr == `A_COEF2) rmux = {24'h0, coef2_q};
        else if (reg_addr == `A_GUARD) rmux = {16'h0, pos_step_q, neg_pct_q};
        else if (reg_addr == `A_KEYSEL) rmux = {26'h0, keysel_q};
        else if (reg_addr == `A_HYST) rmux = {30'h0, hyst_q};
        else if (reg_addr == `A_DET_LO) rmux = det_q[31:0];
        else if (reg_addr == `A_DET_HI) rmux = det_q[63:32];
        else if (reg_addr == `A_ERR_LO) rmux = err_all[31:0];
        else if (reg_addr == `A_ERR_HI) rmux = err_all[63:32];
        else rmux = 32'h0;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rdata_q <= 32'h0;
        else rdata_q <= reg_rd ? rmux : 32'h0;
    end

    assign reg_rdata = rdata_q;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_limit_zero_off: assert property (s1_v_q && su0.di_limit == 4'h0 |=> !det_q[$past(kq)])
        else $error("detect set with zero integrator limit");
    a_integ_confirm: assert property (s1_v_q && !cal && !det_old && below && su0.di_limit != 4'h0
        && di_inc == su0.di_limit && su1.neg_delay == 8'h00 |=> det_q[$past(kq)])
        else $error("integrator reached limit without detect");
    a_integ_decay: assert property (s1_v_q && !cal && !det_old && !below && !above_hys
        && su0.di_limit != 4'h0 |-> nx.detection_integrator == di_dec)
        else $error("integrator did not count down");
    a_integ_clear: assert property (s1_v_q && !cal && !det_old && above_hys
        |-> nx.detection_integrator == 4'h0)
        else $error("integrator not cleared above hysteresis");
    a_release_hold: assert property (s1_v_q && !cal && det_old && !below && st.detection_integrator > 4'h1
        && su0.di_limit != 4'h0 && !neg_fire && !pos_fire |=> det_q[$past(kq)])
        else $error("detect dropped before integrator emptied");
    a_drift_frozen: assert property (s1_v_q && !cal && (det_old || below) && !neg_fire && !pos_fire
        |-> nx.ref_lvl == st.ref_lvl)
        else $error("reference moved during detection");
    a_drift_slew: assert property (s1_v_q && !cal && !neg_fire && !pos_fire
        |-> nx.ref_lvl == st.ref_lvl || nx.ref_lvl == 8'(st.ref_lvl + 8'h01)
        || nx.ref_lvl == 8'(st.ref_lvl - 8'h01))
        else $error("drift step larger than one count");
    a_neg_recal: assert property (s1_v_q && neg_fire |-> nx.ref_lvl == sig ##1 !det_q[$past(kq)])
        else $error("fast recal did not reset reference");
    a_delay_off: assert property (s1_v_q && su1.neg_delay == 8'h00 && su1.pos_delay == 8'h00
        |-> !neg_fire && !pos_fire)
        else $error("recal fired with zero delay");
    a_bound_high: assert property (s1_v_q && nx.ref_lvl > `REF_HIGH_LIMIT |=> eh_q[$past(kq)])
        else $error("high boundary flag missing");
    a_bound_low: assert property (s1_v_q && nx.ref_lvl < `REF_LOW_LIMIT |=> el_q[$past(kq)])
        else $error("low boundary flag missing");

    c_detect: cover property (s1_v_q && nx_det && !det_old);
    c_neg_fire: cover property (s1_v_q && neg_fire);
    c_pos_fire: cover property (s1_v_q && pos_fire);
    c_guard: cover property (s1_v_q && gbon_q[kq] && (gb_low || gb_high));
endmodule : touch_key_tracker
`default_nettype wire

// >>> bench/acq_model.sv
// Acquisition-side model that hands key samples to the tracker
`timescale 1ns/10ps
`default_nettype none
module acq_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [5:0] key,
    input wire logic [7:0] sig,
    output logic sample_valid,
    output touch_pkg::sample_t sample
);
    // Quiet start so the tracker never sees an unknown strobe
    initial begin
        sample_valid = 1'b0;
        sample = '0;
    end
    // One-cycle pulse; payload inverted when idle so stale data is never trusted
    always @(posedge clk) begin
        sample_valid <= go;
        sample <= go ? {key, sig, 2'h1, 8'h10} : ~sample;
    end
endmodule : acq_model
`default_nettype wire

// >>> bench/touch_key_reference_tracker_tb_top.sv
// Self-checking bench for the touch key tracker
`timescale 1ns/10ps
`default_nettype none
`include "touch_defines.svh"
module touch_key_reference_tracker_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic go = 1'b0;
    logic [5:0] key = 6'h00;
    logic [7:0] sig = 8'h00;
    logic sample_valid;
    touch_pkg::sample_t sample;
    logic [63:0] key_detect;
    logic [63:0] full_recal_req;
    logic [7:0] seq [9] = '{8'h50, 8'h50, 8'h80, 8'h50, 8'h50, 8'h64, 8'h50, 8'h50, 8'h80};
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 clk = ~clk;
    acq_model i_acq_model (.clk(clk), .go(go), .key(key), .sig(sig), .sample_valid(sample_valid), .sample(sample));
    touch_key_tracker #(.NKEYS(64)) i_touch_key_tracker (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample(sample), .key_detect(key_detect), .full_recal_req(full_recal_req));
    // Integrator outcome after n touched samples; limit zero never detects
    function automatic logic det_exp(input int n, input int lim);
        return lim != 0 && n >= lim;
    endfunction : det_exp
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Gap of several cycles keeps samples of one key well apart
    task automatic smp(input logic [5:0] k, input logic [7:0] s);
        @(posedge clk);
        key <= k;
        sig <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : smp
    // Thresholds 0x20 down and 0x40 up, chosen limit and timing word
    task automatic setk(input logic [5:0] k, input logic [3:0] lim, input logic [31:0] t);
        wr(`A_KEYSEL, {26'h0, k});
        wr(`A_SETUP_THR, {12'h000, lim, 8'h40, 8'h20});
        wr(`A_SETUP_TIME, t);
    endtask : setk
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        void'($urandom(32'h5f49));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk(full_recal_req, {64{1'b1}});
        rd(`A_COEF1, 32'h05e9);
        rd(`A_COEF2, 32'h08);
        rd(8'h30, 32'h0);
        rd(`A_SETUP_THR, 32'h0);
        setk(6'd0, 4'h3, 32'h0);
        setk(6'd1, 4'h3, 32'h1);
        setk(6'd2, 4'h0, 32'h0);
        smp(6'd0, 8'h80);
        smp(6'd1, 8'hbf);
        smp(6'd2, 8'h80);
        chk(full_recal_req[2:0], 64'h0);
        rd(`A_ERR_LO, 32'h0);
        smp(6'd1, 8'hff);
        rd(`A_ERR_LO, 32'h2);
        // Lock, then host recal clears boundary flag; a second host recal arms guard
        wr(`A_GUARD, 32'h0000_0001);
        wr(`A_CMD, 32'h0000_0004);
        wr(`A_CMD, {16'h0, 2'b00, 6'd1, 8'h01});
        #1 chk(full_recal_req[1], 1'b1);
        smp(6'd1, 8'h80);
        rd(`A_ERR_LO, 32'h0);
        wr(`A_CMD, {16'h0, 2'b00, 6'd1, 8'h01});
        smp(6'd1, 8'h40);
        rd(`A_ERR_LO, 32'h0);
        smp(6'd1, 8'h40);
        rd(`A_ERR_LO, 32'h2);
        for (int i = 0; i < 9; i++) begin
            smp(6'd0, seq[i]);
            chk(key_detect[0], i == 7 || i == 8);
        end
        for (int i = 0; i < 2; i++) begin
            smp(6'd0, 8'h80);
            chk(key_detect[0], i == 0);
        end
        for (int n = 1; n <= 4; n++) begin
            smp(6'd2, 8'h50);
            chk(key_detect[2], det_exp(n, 0));
        end
        repeat (8) begin
            smp(6'd0, 8'h69 + 8'($urandom % 8'h97));
            chk(key_detect[0], 1'b0);
        end
        setk(6'd0, 4'h3, 32'h0002_0000);
        for (int n = 1; n <= 3; n++) begin
            smp(6'd0, 8'h50);
            chk(key_detect[0], n == 3);
        end
        smp(6'd0, 8'h50);
        chk(key_detect[0], 1'b0);
        for (int n = 1; n <= 3; n++) begin
            smp(6'd0, 8'h28);
            chk(key_detect[0], n == 3);
        end
        report_and_stop();
    end
endmodule : touch_key_reference_tracker_tb_top
`default_nettype wire
